// ### common/idt_pkg.sv
// Package for the instruction decode and timing block.
// Assumes a single 20 MHz core clock and 14-bit program words.
package idt_pkg;
   localparam int          IDT_WORD_W     = 14;
   localparam int          IDT_PC_W       = 15;
   localparam int          IDT_PHASES     = 4;    // Clocks per cycle
   localparam logic [1:0]  IDT_PHASE_LAST = 2'h3;
   localparam logic [1:0]  IDT_PHASE_RST  = 2'h0;
   localparam logic [1:0]  IDT_PHASE_RD   = 2'h1;
   localparam logic [1:0]  IDT_PHASE_WR   = 2'h3;
   localparam logic [14:0] IDT_PC_RST     = 15'h0000;
   localparam logic [6:0]  IDT_FILE_MAX   = 7'h7F;
   localparam logic [6:0]  IDT_INDF0_ADDR = 7'h00;
   localparam logic [6:0]  IDT_INDF1_ADDR = 7'h01;
   localparam logic [1:0]  IDT_CYC_ONE    = 2'h1;
   localparam logic [1:0]  IDT_CYC_TWO    = 2'h2;
   localparam logic [1:0]  IDT_CYC_THREE  = 2'h3;
   localparam int          IDT_GRP_MSB    = 13;
   localparam int          IDT_D_POS      = 7;
   localparam int          IDT_B_LSB      = 7;
   localparam int          IDT_N_POS_INC  = 2;
   localparam int          IDT_N_POS_OFF  = 6;

   typedef enum logic [1:0] {
      IDT_GRP_BYTE = 2'b00,
      IDT_GRP_BIT  = 2'b01,
      IDT_GRP_LIT  = 2'b10
   } idt_group_type;

   typedef enum logic [1:0] {
      IDT_MM_PRE_INC  = 2'b00,
      IDT_MM_PRE_DEC  = 2'b01,
      IDT_MM_POST_INC = 2'b10,
      IDT_MM_POST_DEC = 2'b11
   } idt_mode_type;
endpackage

// ### design/idt_phase_gen.sv
// Phase generator: splits each instruction cycle into four clocks.
// Assumes one free-running clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module idt_phase_gen
   import idt_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       rst_b,
   output logic [1:0]      phase,
   output logic            cycle_end
);
   logic [1:0] phase_q;

   // Four oscillator periods per instruction cycle
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         phase_q <= IDT_PHASE_RST;
      end else begin
         phase_q <= phase_q + 2'h1; // RULE_08
      end
   end

   assign phase     = phase_q;
   assign cycle_end = (phase_q == IDT_PHASE_LAST);
endmodule // idt_phase_gen
`default_nettype wire

// ### design/idt_decoder.sv
// Instruction decoder with cycle timing and read-modify-write sequencing.
// Assumes program memory holds instr_word stable for a whole cycle and the
// core reports the skip/branch outcome and pointer target before phase 3.
// Function
// [RULE_01] Every instruction is one 14-bit word holding opcode and operands.
// [RULE_02] Each word is sorted into byte, bit or literal/control group.
// [RULE_03] Instructions not listed as exceptions finish in one cycle.
// [RULE_04] Direct call and call through working register take two cycles.
// [RULE_05] Plain return, literal return and interrupt return take two cycles.
// [RULE_06] Jumps, branches and taken skips take two cycles.
// [RULE_07] Indirect access with pointer into program memory adds one cycle.
// [RULE_08] One instruction cycle is four oscillator clocks.
// [RULE_09] File operands are read, modified, then written; read always done.
// [RULE_10] Destination bit 0 writes working register, 1 writes file.
// [RULE_11] File address field selects one of 0x00 to 0x7F.
// [RULE_12] Bit field selects one bit of the addressed 8-bit register.
// [RULE_13] Pointer number field selects pointer or indirect port 0 or 1.
// [RULE_14] Two-bit mode selects pre/post increment or decrement.
// [RULE_15] Don't-care bits are ignored whatever their value.
// [RULE_16] Non-flow single-word instructions advance the counter by one.
`timescale 1ns/1ps
`default_nettype none
module idt_decoder
   import idt_pkg::*;
(
   input  wire logic [13:0] instr_word,
   input  wire logic        flow_taken,
   input  wire logic        ptr_in_prog,
   input  wire logic        ref_clk,
   input  wire logic        rst_b,
   output logic [14:0]      pc,
   output logic             fetch_strobe,
   output logic [1:0]       group,
   output logic [6:0]       file_addr,
   output logic [2:0]       bit_sel,
   output logic             dest_file,
   output logic             ptr_num,
   output logic [1:0]       ptr_mode,
   output logic             is_ptr_inc,
   output logic             file_rd,
   output logic             file_wr,
   output logic             wreg_wr,
   output logic [1:0]       cycles_total,
   output logic             stall
);
   logic [1:0]    phase;
   logic          cycle_end;
   logic [13:0]   ir_q;
   logic [1:0]    cnt_q;
   logic [1:0]    need_q;
   logic [14:0]   pc_q;
   logic          exec_q;
   idt_group_type grp_d;
   logic          call_i, ret_i, jmp_i, skip_i, file_op, no_dest, indirect_file_port_i;
   logic          multi_i;
   logic [1:0]    need_d;

   idt_phase_gen u_phase (
      .ref_clk   (ref_clk),
      .rst_b     (rst_b),
      .phase     (phase),
      .cycle_end (cycle_end)
   );

   // Group from the top two opcode bits; whole word latched on each fetch
   always_comb begin
      unique case (ir_q[IDT_GRP_MSB -: 2]) // RULE_02
         2'b00:   grp_d = IDT_GRP_BYTE;
         2'b01:   grp_d = IDT_GRP_BIT;
         default: grp_d = IDT_GRP_LIT;
      endcase
   end

   // Class flags; fields marked don't-care are never inspected
   always_comb begin
      call_i  = (ir_q[13:11] == 3'b100) || (ir_q == 14'h000A); // RULE_04
      ret_i   = (ir_q == 14'h0008) || (ir_q == 14'h0009) ||
                (ir_q[13:8] == 6'h34); // RULE_05
      jmp_i   = (ir_q[13:11] == 3'b101) || (ir_q[13:9] == 5'b11001) ||
                (ir_q == 14'h000B); // RULE_06
      skip_i  = (ir_q[13:11] == 3'b011) ||
                (ir_q[13:8] == 6'h0B) || (ir_q[13:8] == 6'h0F); // RULE_06
      // Clear-W form ignores its low two bits
      no_dest = (ir_q[13:2] == 12'h040); // RULE_15
      // Control words share the byte group but name no file register
      file_op = (grp_d == IDT_GRP_BIT) ||
                (grp_d == IDT_GRP_BYTE && ir_q[11:7] != 5'h00 && !no_dest) ||
                (ir_q[13:8] == 6'h3B) || (ir_q[13:8] == 6'h3D) ||
                (ir_q[13:10] == 4'hD && ir_q[9:8] != 2'h0);
      indirect_file_port_i  = file_op && ((ir_q[6:0] == IDT_INDF0_ADDR) ||
                (ir_q[6:0] == IDT_INDF1_ADDR));
      multi_i = call_i || ret_i || jmp_i || (skip_i && flow_taken);
      need_d  = multi_i ? IDT_CYC_TWO : IDT_CYC_ONE; // RULE_03
      if (indirect_file_port_i && ptr_in_prog) begin
         need_d = multi_i ? IDT_CYC_THREE : IDT_CYC_TWO; // RULE_07
      end
   end

   // Instruction register and extra-cycle counter; the count kept on fetch
   // is that of the instruction just finished, so it never shows half-done
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         ir_q   <= 14'h0000;
         cnt_q  <= 2'h0;
         need_q <= IDT_CYC_ONE;
         exec_q <= 1'b0;
      end else if (cycle_end) begin
         if (!exec_q || cnt_q + 2'h1 >= need_d) begin
            ir_q   <= instr_word; // RULE_01
            cnt_q  <= 2'h0;
            exec_q <= 1'b1;
            need_q <= need_d;
         end else begin
            cnt_q  <= cnt_q + 2'h1;
         end
      end
   end

   // Counter advances one word on each fetch
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         pc_q <= IDT_PC_RST;
      end else if (cycle_end && (!exec_q || cnt_q + 2'h1 >= need_d)) begin
         pc_q <= pc_q + 15'h0001; // RULE_16
      end
   end

   assign stall        = exec_q && (cnt_q + 2'h1 < need_d);
   assign fetch_strobe = cycle_end && !stall;
   assign pc           = pc_q;
   assign group        = grp_d;
   assign file_addr    = ir_q[6:0]; // RULE_11
   assign bit_sel      = ir_q[IDT_B_LSB +: 3]; // RULE_12
   assign dest_file    = ir_q[IDT_D_POS]; // RULE_10
   assign is_ptr_inc   = (ir_q[13:3] == 11'h002);
   assign ptr_num      = is_ptr_inc ? ir_q[IDT_N_POS_INC] :
                         ir_q[IDT_N_POS_OFF]; // RULE_13
   assign ptr_mode     = ir_q[1:0]; // RULE_14
   assign cycles_total = need_q;
   // Read always precedes write, even for store-only forms
   assign file_rd = exec_q && file_op && cnt_q == 2'h0 &&
                    phase == IDT_PHASE_RD; // RULE_09
   assign file_wr = exec_q && file_op && phase == IDT_PHASE_WR &&
                    !stall && (grp_d == IDT_GRP_BIT ? !ir_q[11] :
                    ir_q[IDT_D_POS]); // RULE_10
   // Clear-W writes the working register without naming a file
   assign wreg_wr = exec_q && !stall && phase == IDT_PHASE_WR &&
                    (no_dest || (file_op && grp_d != IDT_GRP_BIT &&
                    !ir_q[IDT_D_POS])); // RULE_10

   // Checks
   property p_fetch_period;
      @(posedge ref_clk) disable iff (!rst_b)
         fetch_strobe |-> ##1 !fetch_strobe [*3];
   endproperty
   a_fetch_period: assert property (p_fetch_period) // RULE_08
      else $error("fetch closer than four clocks");
   property p_pc_step;
      @(posedge ref_clk) disable iff (!rst_b)
         fetch_strobe |=> pc == $past(pc) + 15'h0001;
   endproperty
   a_pc_step: assert property (p_pc_step) // RULE_16
      else $error("counter did not step by one");
   property p_rd_before_wr;
      @(posedge ref_clk) disable iff (!rst_b)
         file_rd |-> ##2 (file_wr || wreg_wr || stall ||
         (grp_d == IDT_GRP_BIT && ir_q[11]));
   endproperty
   a_rd_before_wr: assert property (p_rd_before_wr) // RULE_09
      else $error("file read not followed by store");
   property p_excl_dest;
      @(posedge ref_clk) disable iff (!rst_b) !(wreg_wr && file_wr);
   endproperty
   a_excl_dest: assert property (p_excl_dest) // RULE_10
      else $error("both destinations written");
   property p_one_cycle;
      @(posedge ref_clk) disable iff (!rst_b)
         (cycle_end && exec_q && !multi_i && !(indirect_file_port_i && ptr_in_prog))
         |-> !stall;
   endproperty
   a_one_cycle: assert property (p_one_cycle) // RULE_03
      else $error("simple instruction stalled");
   property p_call_two;
      @(posedge ref_clk) disable iff (!rst_b)
         (cycle_end && exec_q && cnt_q == 2'h0 && call_i) |=>
         (cnt_q == 2'h1);
   endproperty
   a_call_two: assert property (p_call_two) // RULE_04
      else $error("call did not hold a second cycle");
   property p_multi_stall;
      @(posedge ref_clk) disable iff (!rst_b)
         (exec_q && cnt_q == 2'h0 && phase == IDT_PHASE_RST &&
         (call_i || ret_i)) |-> stall;
   endproperty
   a_multi_stall: assert property (p_multi_stall) // RULE_04
      else $error("call or return did not take two cycles");
   property p_jump_stall;
      @(posedge ref_clk) disable iff (!rst_b)
         (exec_q && cnt_q == 2'h0 && jmp_i) |-> stall;
   endproperty
   a_jump_stall: assert property (p_jump_stall) // RULE_06
      else $error("jump did not take two cycles");
   property p_indirect_file_port_extra;
      @(posedge ref_clk) disable iff (!rst_b)
         (exec_q && cnt_q == 2'h0 && indirect_file_port_i && ptr_in_prog) |-> stall;
   endproperty
   a_indirect_file_port_extra: assert property (p_indirect_file_port_extra) // RULE_07
      else $error("indirect program access lacked extra cycle");
   property p_ret_flag;
      @(posedge ref_clk) disable iff (!rst_b)
         (exec_q && ir_q == 14'h0008 && cnt_q == 2'h0) |-> stall;
   endproperty
   a_ret_flag: assert property (p_ret_flag) // RULE_05
      else $error("return did not take two cycles");
   c_call: cover property (@(posedge ref_clk) exec_q && call_i &&
      cnt_q == 2'h1);
   c_skip: cover property (@(posedge ref_clk) skip_i && flow_taken && stall);
   c_three: cover property (@(posedge ref_clk) need_q == IDT_CYC_THREE);
endmodule // idt_decoder
`default_nettype wire

// ### verif/idt_prog_mem.sv
// Program memory model: returns the word addressed by the counter.
// Assumes the bench fills the array and never rewrites a word in flight.
`timescale 1ns/1ps
`default_nettype none
module idt_prog_mem (
   input  wire logic [14:0] pc,
   output logic      [13:0] instr_word
);
   logic [13:0] mem [256];

   // Low address bits only, so the counter wraps into the array past word 255
   assign instr_word = mem[pc[7:0]];
endmodule // idt_prog_mem
`default_nettype wire

// ### verif/idt_decoder_tb.sv
// Testbench for the decoder: random words, cycle spacing and field checks.
// Assumes a 20 MHz clock and program memory modelled by idt_prog_mem.
`timescale 1ns/1ps
`default_nettype none
module idt_decoder_tb;
   import idt_pkg::*;
   logic        ref_clk = 1'b0, rst_b = 1'b0;
   logic        flow_taken = 1'b0, ptr_in_prog = 1'b0;
   logic [13:0] instr_word;
   logic [14:0] pc;
   logic        fetch_strobe, dest_file, ptr_num, is_ptr_inc, stall;
   logic        file_rd, file_wr, wreg_wr;
   logic [1:0]  group, ptr_mode, cycles_total;
   logic [6:0]  file_addr;
   logic [2:0]  bit_sel;
   int          n_fail = 0, checks_done = 0;
   logic [31:0] seed = 32'h2279;

   // Clock at 50 ns period
   always #25 ref_clk = ~ref_clk;

   idt_decoder uut (.instr_word(instr_word), .flow_taken(flow_taken),
      .ptr_in_prog(ptr_in_prog), .ref_clk(ref_clk), .rst_b(rst_b),
      .pc(pc), .fetch_strobe(fetch_strobe), .group(group),
      .file_addr(file_addr), .bit_sel(bit_sel), .dest_file(dest_file),
      .ptr_num(ptr_num), .ptr_mode(ptr_mode), .is_ptr_inc(is_ptr_inc),
      .file_rd(file_rd), .file_wr(file_wr), .wreg_wr(wreg_wr),
      .cycles_total(cycles_total), .stall(stall));
   idt_prog_mem prog (.pc(pc), .instr_word(instr_word));

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // Mix of byte, bit, flow and pointer words; half the file ops hit 0x00/1
   function automatic logic [13:0] gen_word();
      logic [31:0] r;
      logic [6:0]  f;
      r = xs();
      f = r[11] ? {6'h00, r[16]} : r[22:16];
      case (r[3:0])
         4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5:
            return {2'h0, (r[7:4] == 4'h0) ? 4'h1 : r[7:4],
                    r[8] | (r[7:4] <= 4'h1), f};
         4'h6, 4'h7, 4'h8: return {2'h1, r[9:8], r[26:24], f};
         4'h9: return {12'h002, r[5:4]};
         4'hA: return {6'h34, r[31:24]};
         4'hB: return {3'h5, r[26:16]};
         4'hC: return {3'h4, r[26:16]};
         4'hD: return {5'h19, r[24:16]};
         4'hE: return r[12] ? {11'h002, r[18:16]} : {7'h62, r[22:16]};
         default: return r[12] ? {6'h30, r[31:24]} :
                         {2'h3, r[13] ? 4'hD : 4'hB, r[8], f};
      endcase
   endfunction

   // Words naming a file register whose result goes where d says
   function automatic logic is_byte_file(logic [13:0] w);
      return (w[13:12] == 2'h0 && w[11:7] != 5'h00 && w[13:2] != 12'h040) ||
             w[13:8] == 6'h3B || w[13:8] == 6'h3D ||
             (w[13:10] == 4'hD && w[9:8] != 2'h0);
   endfunction

   // Instruction cycles expected for a word with the given flow and pointer
   function automatic int exp_cyc(logic [13:0] w, logic t, logic ip);
      int c;
      c = 1;
      if (w[13:11] == 3'h4 || w[13:11] == 3'h5 || w[13:8] == 6'h34 ||
          w[13:9] == 5'h19 || (w[13:2] == 12'h002)) c = 2;
      if (t && (w[13:11] == 3'h3 || w[13:8] == 6'h0B || w[13:8] == 6'h0F))
         c = 2;
      if (ip && w[6:1] == 6'h00 && (w[13:12] == 2'h1 || is_byte_file(w)))
         c++;
      return c;
   endfunction

   // Field compare; the other kinds resize to 16 bits on purpose and land here
   task automatic chk_fld(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_cyc(input int got, input int exp);
      chk_fld(16'(got), 16'(exp));
   endtask

   task automatic chk_pc(input logic [14:0] got, input logic [14:0] exp);
      chk_fld({1'b0, got}, {1'b0, exp});
   endtask

   task automatic chk_stb(input logic [11:0] got, input logic [11:0] exp);
      chk_fld({4'h0, got}, {4'h0, exp});
   endtask

   task automatic report_and_stop();
      if (n_fail == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Counts clocks and strobes up to the next fetch; the bound cuts a hang
   task automatic wait_fetch(output int n, output logic [3:0] rd,
                             output logic [3:0] wr, output logic [3:0] ww);
      n = 0;
      rd = 4'h0;
      wr = 4'h0;
      ww = 4'h0;
      do begin
         @(negedge ref_clk);
         n++;
         // New condition inputs only after the previous fetch edge
         if (n == 1) begin
            flow_taken = xs() > 32'h8000_0000;
            ptr_in_prog = xs() > 32'h8000_0000;
         end
         rd += file_rd;
         wr += file_wr;
         ww += wreg_wr;
         if (n > 16) begin
            n_fail++;
            report_and_stop();
         end
      end while (fetch_strobe !== 1'b1);
   endtask

   initial begin
      logic [13:0] w;
      logic [14:0] p;
      logic [3:0]  rd, wr, ww;
      logic [1:0]  e_prev;
      int          n;
      for (int i = 0; i < 256; i++) prog.mem[i] = gen_word();
      prog.mem[0] = 14'h0B81; // Skip-decrement on indirect port 1 first
      prog.mem[1] = 14'h000A; // Then a call through the working register
      e_prev = IDT_CYC_ONE; // Word in IR after reset is a one-cycle no-op
      repeat (2) @(negedge ref_clk);
      rst_b = 1'b1;
      wait_fetch(n, rd, wr, ww);
      for (int i = 0; i < 2000; i++) begin
         w = instr_word;
         p = pc;
         wait_fetch(n, rd, wr, ww);
         chk_cyc(n, 4 * exp_cyc(w, flow_taken, ptr_in_prog));
         // Count on show is that of the instruction before this one
         chk_fld({14'h0000, cycles_total}, {14'h0000, e_prev});
         e_prev = 2'(exp_cyc(w, flow_taken, ptr_in_prog));
         chk_fld({15'h0000, stall}, 16'h0000);
         if (exp_cyc(w, 1'b1, 1'b0) == 1) chk_pc(pc, p + 15'h1);
         if (is_byte_file(w)) begin
            chk_fld({6'h00, group, dest_file, file_addr}, {6'h00, w[13], 1'b0, w[7:0]});
            chk_stb({rd, wr, ww}, {4'h1, 3'h0, w[7], 3'h0, !w[7]});
         end else if (w[13:12] == 2'h1) begin
            chk_fld({4'h0, group, bit_sel, file_addr}, {4'h0, 2'h1, w[9:0]});
            chk_stb({rd, wr, ww}, {4'h1, 3'h0, !w[11], 4'h0});
         end else chk_stb({rd, wr, 4'h0}, 12'h000);
         if (w[13]) chk_fld({14'h0000, group}, 16'h0002);
         if (w[13:3] == 11'h002) chk_fld({12'h000, is_ptr_inc, ptr_num, ptr_mode}, {13'h0001, w[2:0]});
         else chk_fld({15'h0000, is_ptr_inc}, 16'h0000);
         if (w[13:7] == 7'h62) chk_fld({15'h0000, ptr_num}, {15'h0000, w[6]});
         // Refill the spent slot unless it is the word now being fetched
         if (pc[7:0] != p[7:0]) prog.mem[p[7:0]] = gen_word();
      end
      report_and_stop();
   end
endmodule // idt_decoder_tb
`default_nettype wire
